// ==== rtl/slot_status_consts.svh ====
// Constants for the slot status image builder: image layout, bit positions, error codes, register map.
// Assumes inclusion by bare name from the package and the design file.
// Contract
// - Image holds two bytes for the bus coupling and two per slot.
// - Image bytes 0 and 1 carry the global status word.
// - Slot pairs follow the coupling bytes in ascending order from slot 1.
// - First slot byte is module diagnostics, second is type dependent channel diagnostics.
// - Dual-width module takes four bytes; only its first slot reports active.
// - Dual-width bytes 1 and 3 are module layout, 2 and 4 channel layout.
// - Module byte bit 7 shows module active.
// - Module byte bit 6 shows simulation on at least one channel.
// - Module byte bit 5 shows an error; bit 4 reads zero.
// - Module byte bits 3 to 0 hold the four bit error code.
// - Code 0 means no fault; code 1 means timeout, no module inserted.
// - Codes 2 to 6 are internal bus errors; 7 and 8 unused.
// - Code 9 when inserted module type differs from configured type.
// - Code 10 is internal module error; 11 to 15 unused.
// - Module types without channel diagnostics give a zero channel byte.
// - Digital layout: even bits data, odd bits status; byte 4 covers channels 5-8.
// - Channel status bit is zero when valid, one when invalid.
// - Two-channel digital layout: bits 0 and 1 data, bits 2-7 zero.
// - Counter layout: bit 0 status, bit 1 validity, bit 3 direction.
// - Current layout: bits 0/4 undershoot, 1/5 status, others zero.
// - Fourth byte only for dual-width; channels beyond count read zero (two-channel digital and counter layouts ignore the count).
// - Global word bits 11 to 8 hold the station error code.
// - Global word bit 7 set when more than one error is active.
`ifndef SLOT_STATUS_CONSTS_SVH
`define SLOT_STATUS_CONSTS_SVH

// Image layout.
`define IMG_HDR_BYTES     2
`define IMG_BYTES_PER_SLOT 2

// Module diagnostic byte fields.
`define MOD_ACTIVE_BIT    7
`define MOD_SIM_BIT       6
`define MOD_ERR_BIT       5
`define MOD_CODE_LSB      0

// Module error codes.
`define ERR_NONE          4'h0
`define ERR_TIMEOUT       4'h1
`define ERR_BUS_MIN       4'h2
`define ERR_BUS_MAX       4'h6
`define ERR_TYPE          4'h9
`define ERR_MODULE        4'ha

// Channel byte fields.
`define CNT_STATUS_BIT    0
`define CNT_VALID_BIT     1
`define CNT_DIR_BIT       3
`define CUR_HI_LSB        4
`define CH_PER_DIG_BYTE   4
`define CH_PER_CUR_BYTE   2

// Global status word fields.
`define GSW_ACTIVE_BIT    15
`define GSW_SIM_BIT       14
`define GSW_ERR_BIT       13
`define GSW_GEN_BIT       12
`define GSW_CODE_LSB      8
`define GSW_MULTI_BIT     7
`define GSW_PARAM_BIT     6
`define GSW_COUNT_MAX     6'h3f

// Register map.
`define CTRL_ADDR         8'hff
`define CTRL_TYPE_CHK_BIT 0
`define CTRL_RESET        8'h01

`endif

// ==== rtl/slot_status_pkg.sv ====
// Types shared by the slot status image builder.
// Assumes the constants header is on the include path.
`include "slot_status_consts.svh"

package slot_status_pkg;

   // Channel diagnostic layout class of the module in a slot.
   typedef enum logic [2:0] {
      lay_none,
      lay_digital,
      lay_digital2,
      lay_counter,
      lay_current
   } layout_e;

   typedef logic [7:0] byte_t;

endpackage : slot_status_pkg

// ==== rtl/slot_status_image_builder.sv ====
// Slot status image builder: assembles the station status image from per-slot module states.
// Assumes slot inputs come from other logic or pins and are asynchronous to clk_in; all are resynchronised.
// Software reads the image over a simple byte port with read data one cycle after the strobe.
`include "slot_status_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module slot_status_image_builder
   import slot_status_pkg::*;
#(
   parameter int NUM_SLOTS = 8,
   parameter int ADDR_W    = 8
)(
   // Clock and reset.
   input  wire logic                   clk_in,
   input  wire logic                   rst_b_in,
   // Register port.
   input  wire logic [ADDR_W-1:0]      addr_in,
   input  wire logic [7:0]             wdata_in,
   input  wire logic                   wr_in,
   input  wire logic                   rd_in,
   output logic      [7:0]             rdata_out,
   // Station level state.
   input  wire logic                   com_active_in,
   input  wire logic                   gen_err_in,
   input  wire logic                   param_busy_in,
   input  wire logic [3:0]             station_code_in,
   // Per-slot module state, slot 1 in the lowest lane.
   input  wire logic [NUM_SLOTS-1:0]   present_in,
   input  wire logic [NUM_SLOTS-1:0]   active_in,
   input  wire logic [NUM_SLOTS-1:0]   sim_in,
   input  wire logic [NUM_SLOTS-1:0]   mod_err_in,
   input  wire logic [NUM_SLOTS-1:0]   dual_in,
   input  wire logic [4*NUM_SLOTS-1:0] bus_code_in,
   input  wire logic [8*NUM_SLOTS-1:0] cfg_type_in,
   input  wire logic [8*NUM_SLOTS-1:0] ins_type_in,
   input  wire logic [3*NUM_SLOTS-1:0] layout_in,
   input  wire logic [4*NUM_SLOTS-1:0] chan_cnt_in,
   input  wire logic [8*NUM_SLOTS-1:0] chan_val_in,
   input  wire logic [8*NUM_SLOTS-1:0] chan_inv_in
);

   localparam int IMG_BYTES = `IMG_HDR_BYTES + `IMG_BYTES_PER_SLOT * NUM_SLOTS;
   localparam int SW        = 7 + NUM_SLOTS * 48;

   // Every slot and station input passes two flip-flops; the slot data are gathered into one vector so one pair serves all.
   logic [SW-1:0] sync1;
   logic [SW-1:0] sync2;
   wire  [SW-1:0] raw;

   assign raw = {station_code_in, param_busy_in, gen_err_in, com_active_in,
                 chan_inv_in, chan_val_in, chan_cnt_in, layout_in, ins_type_in, cfg_type_in,
                 bus_code_in, dual_in, mod_err_in, sim_in, active_in, present_in};

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= raw;
         sync2 <= sync1;
      end
   end

   // Unpacked, synchronised copies.
   wire       [3:0]             s_code;
   wire                         s_param;
   wire                         s_gen;
   wire                         s_com;
   wire       [8*NUM_SLOTS-1:0] s_inv;
   wire       [8*NUM_SLOTS-1:0] s_val;
   wire       [4*NUM_SLOTS-1:0] s_cnt;
   wire       [3*NUM_SLOTS-1:0] s_lay;
   wire       [8*NUM_SLOTS-1:0] s_ins;
   wire       [8*NUM_SLOTS-1:0] s_cfg;
   wire       [4*NUM_SLOTS-1:0] s_bus;
   wire       [NUM_SLOTS-1:0]   s_dual;
   wire       [NUM_SLOTS-1:0]   s_merr;
   wire       [NUM_SLOTS-1:0]   s_sim;
   wire       [NUM_SLOTS-1:0]   s_act;
   wire       [NUM_SLOTS-1:0]   s_pres;

   assign {s_code, s_param, s_gen, s_com, s_inv, s_val, s_cnt, s_lay, s_ins, s_cfg,
           s_bus, s_dual, s_merr, s_sim, s_act, s_pres} = sync2;

   // Control register: type check enable.
   logic [7:0] ctrl;
   wire        type_chk;
   wire        ctrl_hit;

   assign ctrl_hit = (addr_in == ADDR_W'(`CTRL_ADDR));
   assign type_chk = ctrl[`CTRL_TYPE_CHK_BIT];

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ctrl <= `CTRL_RESET;
      end else if (wr_in && ctrl_hit) begin
         ctrl <= wdata_in & `CTRL_RESET;
      end
   end

   // Channel byte for one half of a module; half 1 is the fourth byte of a dual-width module.
   function automatic byte_t chan_byte(input logic [2:0] lay_code, input logic half,
                                       input logic [7:0] val, input logic [7:0] inv,
                                       input logic [3:0] cnt);
      byte_t   b;
      layout_e lay;
      int      ch;
      b   = '0;
      lay = layout_e'(lay_code);
      ch  = 0;
      unique case (lay)
         lay_digital: begin
            for (int k = 0; k < `CH_PER_DIG_BYTE; k++) begin
               ch = int'(half) * `CH_PER_DIG_BYTE + k;
               if (ch < int'(cnt)) begin
                  b[2*k]   = val[ch];
                  b[2*k+1] = inv[ch];
               end
            end
         end
         lay_current: begin
            for (int k = 0; k < `CH_PER_CUR_BYTE; k++) begin
               ch = int'(half) * `CH_PER_CUR_BYTE + k;
               if (ch < int'(cnt)) begin
                  b[`CUR_HI_LSB*k]   = val[ch];
                  b[`CUR_HI_LSB*k+1] = inv[ch];
               end
            end
         end
         lay_digital2: begin
            if (!half) begin
               b[1:0] = val[1:0];
            end
         end
         lay_counter: begin
            if (!half) begin
               b[`CNT_STATUS_BIT] = val[0];
               b[`CNT_VALID_BIT]  = inv[0];
               b[`CNT_DIR_BIT]    = val[1];
            end
         end
         default: b = '0;
      endcase
      return b;
   endfunction : chan_byte

   // Per-slot diagnostics; a slot that follows a dual-width first slot mirrors that module.
   byte_t      next_mod  [NUM_SLOTS];
   byte_t      next_chan [NUM_SLOTS];
   wire [NUM_SLOTS-1:0] second;
   wire [NUM_SLOTS-1:0] slot_err;
   wire [NUM_SLOTS-1:0] slot_sim;

   genvar s;
   generate
      for (s = 0; s < NUM_SLOTS; s++) begin : g_slot
         wire [3:0] own_code;
         wire [3:0] bus_c;
         wire       mismatch;
         wire       src_dual;
         wire [3:0] code;

         // A dual request on the last slot has no partner and is ignored.
         if (s == 0) begin : g_first
            assign second[s] = 1'b0;
         end else begin : g_next
            assign second[s] = g_slot[s-1].src_dual;
         end

         assign bus_c    = s_bus[4*s +: 4];
         assign mismatch = type_chk && (s_cfg[8*s +: 8] != s_ins[8*s +: 8]);
         // Fault priority: a missing module hides every other cause.
         assign own_code = !s_pres[s]                                     ? `ERR_TIMEOUT :
                           (bus_c >= `ERR_BUS_MIN && bus_c <= `ERR_BUS_MAX) ? bus_c :
                           mismatch                                       ? `ERR_TYPE :
                           s_merr[s]                                      ? `ERR_MODULE :
                                                                            `ERR_NONE;
         assign src_dual = (s < NUM_SLOTS - 1) && s_dual[s] && !second[s];

         if (s == 0) begin : g_code0
            assign code = own_code;
         end else begin : g_coden
            assign code = second[s] ? g_slot[s-1].own_code : own_code;
         end

         assign slot_err[s] = (code != `ERR_NONE) && !second[s];
         assign slot_sim[s] = s_sim[s] && !second[s];

         always_comb begin
            next_mod[s] = '0;
            next_mod[s][`MOD_CODE_LSB +: 4] = code;
            next_mod[s][`MOD_ERR_BIT]       = (code != `ERR_NONE);
            if (second[s]) begin
               next_mod[s][`MOD_SIM_BIT] = s_sim[s-1 < 0 ? 0 : s-1];
            end else begin
               next_mod[s][`MOD_SIM_BIT]    = s_sim[s];
               next_mod[s][`MOD_ACTIVE_BIT] = s_act[s] && s_pres[s];
            end
         end

         always_comb begin
            if (second[s]) begin
               next_chan[s] = chan_byte(s_lay[3*(s-1 < 0 ? 0 : s-1) +: 3], 1'b1,
                                        s_val[8*(s-1 < 0 ? 0 : s-1) +: 8],
                                        s_inv[8*(s-1 < 0 ? 0 : s-1) +: 8],
                                        s_cnt[4*(s-1 < 0 ? 0 : s-1) +: 4]);
            end else begin
               next_chan[s] = chan_byte(s_lay[3*s +: 3], 1'b0, s_val[8*s +: 8],
                                        s_inv[8*s +: 8], s_cnt[4*s +: 4]);
            end
         end
      end
   endgenerate

   // Error count over station and slots; the count saturates at the field width.
   function automatic logic [5:0] count_errs(input logic [NUM_SLOTS-1:0] v, input logic st);
      logic [6:0] n;
      n = {6'h00, st};
      for (int i = 0; i < NUM_SLOTS; i++) begin
         n = n + {6'h00, v[i]};
      end
      return (n > {1'b0, `GSW_COUNT_MAX}) ? `GSW_COUNT_MAX : n[5:0];
   endfunction : count_errs

   wire [5:0]  err_count;
   logic [15:0] next_gsw;

   assign err_count = count_errs(slot_err, s_code != `ERR_NONE);

   // Global status word: high byte first in the image.
   always_comb begin
      next_gsw                       = '0;
      next_gsw[5:0]                  = err_count;
      next_gsw[`GSW_PARAM_BIT]       = s_param;
      next_gsw[`GSW_MULTI_BIT]       = (err_count > 6'h01);
      next_gsw[`GSW_CODE_LSB +: 4]   = s_code;
      next_gsw[`GSW_GEN_BIT]         = s_gen;
      next_gsw[`GSW_ERR_BIT]         = (err_count != 6'h00);
      next_gsw[`GSW_SIM_BIT]         = |slot_sim;
      next_gsw[`GSW_ACTIVE_BIT]      = s_com;
   end

   // Image storage, refreshed on every clock from the synchronised state.
   byte_t image [IMG_BYTES];

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         for (int i = 0; i < IMG_BYTES; i++) begin
            image[i] <= '0;
         end
      end else begin
         image[0] <= next_gsw[15:8];
         image[1] <= next_gsw[7:0];
         for (int i = 0; i < NUM_SLOTS; i++) begin
            image[`IMG_HDR_BYTES + `IMG_BYTES_PER_SLOT*i]     <= next_mod[i];
            image[`IMG_HDR_BYTES + `IMG_BYTES_PER_SLOT*i + 1] <= next_chan[i];
         end
      end
   end

   // Read decode; writes to the image are ignored because the image is read-only.
   wire        img_hit;
   wire [7:0]  rd_mux;

   assign img_hit = (int'(addr_in) < IMG_BYTES);
   assign rd_mux  = img_hit  ? image[img_hit ? int'(addr_in) : 0] :
                    ctrl_hit ? ctrl : 8'h00;

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rdata_out <= 8'h00;
      end else begin
         rdata_out <= rd_in ? rd_mux : 8'h00;
      end
   end

endmodule : slot_status_image_builder

`default_nettype wire

// ==== testbench/io_slot_model.sv ====
// Slot model: the state of each plugged I/O module, driven onto the slot lanes.
// Assumes callers enter its tasks just after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module io_slot_model #(parameter int N = 8) (
   // Slot lanes, slot 1 in lane 0.
   output var logic [N-1:0]   present_out,
   output var logic [N-1:0]   active_out,
   output var logic [N-1:0]   sim_out,
   output var logic [N-1:0]   err_out,
   output var logic [N-1:0]   dual_out,
   output var logic [4*N-1:0] bus_code_out,
   output var logic [8*N-1:0] cfg_out,
   output var logic [8*N-1:0] ins_out,
   output var logic [3*N-1:0] layout_out,
   output var logic [4*N-1:0] cnt_out,
   output var logic [8*N-1:0] val_out,
   output var logic [8*N-1:0] inv_out
);
   // Power-up: every slot is empty.
   initial begin
      {present_out, active_out, sim_out, err_out, dual_out, bus_code_out} = '0;
      {cfg_out, ins_out, layout_out, cnt_out, val_out, inv_out} = '0;
   end

   // Plugs a module; flags are sim, error, dual and type mismatch from bit 0 up.
   task automatic plug(input int s, input logic [2:0] lay, input logic [3:0] c, input logic [7:0] v, i,
                       input logic [3:0] b, f);
      present_out[s] <= 1'b1;
      active_out[s] <= 1'b1;
      sim_out[s] <= f[0];
      err_out[s] <= f[1];
      dual_out[s] <= f[2];
      ins_out[8*s+:8] <= {7'h00, f[3]};
      bus_code_out[4*s+:4] <= b;
      layout_out[3*s+:3] <= lay;
      cnt_out[4*s+:4] <= c;
      val_out[8*s+:8] <= v;
      inv_out[8*s+:8] <= i;
   endtask : plug

   // An empty slot's lanes float, so they show junk that must not leak into the image.
   task automatic pull(input int s);
      present_out[s] <= 1'b0;
      active_out[s] <= 1'b1;
      bus_code_out[4*s+:4] <= 4'h3;
      ins_out[8*s+:8] <= ~ins_out[8*s+:8];
      val_out[8*s+:8] <= ~val_out[8*s+:8];
   endtask : pull

   // Keeps a module plugged but stops it, as during a restart.
   task automatic halt(input int s);
      active_out[s] <= 1'b0;
   endtask : halt
endmodule : io_slot_model
`default_nettype wire

// ==== testbench/slot_status_properties.sv ====
// Checker for the slot status image builder, bound to its top module.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
module slot_status_checker #(parameter int NUM_SLOTS = 8, parameter int ADDR_W = 8) (
   // Clock and reset.
   input wire logic                   clk_in,
   input wire logic                   rst_b_in,
   // Register port.
   input wire logic [ADDR_W-1:0]      addr_in,
   input wire logic                   rd_in,
   input wire logic [7:0]             rdata_out,
   // Station and slot state.
   input wire logic                   com_active_in,
   input wire logic [3:0]             station_code_in,
   input wire logic [NUM_SLOTS-1:0]   present_in,
   input wire logic [3*NUM_SLOTS-1:0] layout_in
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);

   // Read decodes; the image end moves with the slot count.
   wire logic mod_rd = rd_in && addr_in >= 2 && addr_in < 2 + 2 * NUM_SLOTS && !addr_in[0];
   wire logic gap_rd = rd_in && addr_in >= 2 + 2 * NUM_SLOTS && addr_in != '1;

   // Five stable cycles cover the two sync stages and the image register.
   idle_zero_a: assert property (!rd_in |=> rdata_out == 8'h00)
      else $error("read data not idle");
   gap_zero_a: assert property (gap_rd |=> rdata_out == 8'h00)
      else $error("unmapped byte not zero");
   absent_slot_a: assert property ((!present_in[0])[*5] ##0 (rd_in && addr_in == 2) |=> (rdata_out & 8'hbf) == 8'h21)
      else $error("empty slot not timeout");
   rsvd_bit_a: assert property (mod_rd |=> !rdata_out[4])
      else $error("reserved bit set");
   err_flag_a: assert property (mod_rd |=> rdata_out[5] == (rdata_out[3:0] != 4'h0))
      else $error("error flag disagrees with code");
   code_set_a: assert property (mod_rd |=> rdata_out[3:0] inside {[4'h0:4'h6], 4'h9, 4'ha})
      else $error("unused error code");
   station_code_a: assert property (($stable(station_code_in) && $stable(com_active_in))[*5] ##0
      (rd_in && addr_in == 0) |=> rdata_out[3:0] == $past(station_code_in) && rdata_out[7] == $past(com_active_in))
      else $error("global word high byte wrong");
   multi_err_a: assert property (rd_in && addr_in == 1 |=> rdata_out[7] == (rdata_out[5:0] > 6'h01))
      else $error("multiple error flag wrong");
   none_chan_a: assert property ((layout_in[2:0] == 3'h0)[*5] ##0 (rd_in && addr_in == 3) |=> rdata_out == 8'h00)
      else $error("channel byte not zero");

   // Main scenarios.
   cover property (rd_in && addr_in == 1);
   cover property (mod_rd ##1 rdata_out[5]);
   cover property (rd_in && addr_in == '1);
endmodule : slot_status_checker

bind slot_status_image_builder slot_status_checker #(.NUM_SLOTS(NUM_SLOTS), .ADDR_W(ADDR_W)) slot_status_checker_i (
   .clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in), .rd_in(rd_in), .rdata_out(rdata_out),
   .com_active_in(com_active_in), .station_code_in(station_code_in), .present_in(present_in), .layout_in(layout_in));
`default_nettype wire

// ==== testbench/slot_status_image_builder_bench.sv ====
// Bench for the slot status image builder: scenario tasks over the byte port.
// Assumes the slot model drives every slot lane of the design.
`timescale 1ns/100ps
`default_nettype none
module slot_status_image_builder_bench;
   import slot_status_pkg::*;
   logic clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out;
   logic wr_in = 1'b0, rd_in = 1'b0, com_in = 1'b0, gen_in = 1'b0, par_in = 1'b0;
   logic [3:0] stc_in = 4'h0;
   logic [7:0] pr, ac, si, er, du;
   logic [31:0] bc, cn;
   logic [63:0] cf, it, vl, iv;
   logic [23:0] ly;
   int error_cnt = 0, num_checks = 0;

   // 50 MHz clock.
   always #10 clk_in = ~clk_in;

   slot_status_image_builder slot_status_image_builder_i (
      .clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
      .rd_in(rd_in), .rdata_out(rdata_out), .com_active_in(com_in), .gen_err_in(gen_in),
      .param_busy_in(par_in), .station_code_in(stc_in), .present_in(pr), .active_in(ac), .sim_in(si),
      .mod_err_in(er), .dual_in(du), .bus_code_in(bc), .cfg_type_in(cf), .ins_type_in(it),
      .layout_in(ly), .chan_cnt_in(cn), .chan_val_in(vl), .chan_inv_in(iv));
   io_slot_model io_slot_model_i (
      .present_out(pr), .active_out(ac), .sim_out(si), .err_out(er), .dual_out(du), .bus_code_out(bc),
      .cfg_out(cf), .ins_out(it), .layout_out(ly), .cnt_out(cn), .val_out(vl), .inv_out(iv));

   task automatic stop_test;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : stop_test

   task automatic chk(input string n, input logic [7:0] e, g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, d);
      @(posedge clk_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= d;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe, so they are sampled mid-cycle there.
   task automatic rd(input logic [7:0] a, e);
      @(posedge clk_in);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge clk_in);
      rd_in <= 1'b0;
      @(negedge clk_in);
      chk($sformatf("byte %h", a), e, rdata_out);
   endtask : rd

   // Inputs pass two sync stages and the image register before they show.
   task automatic settle;
      repeat (4) @(posedge clk_in);
   endtask : settle

   // Plugs slot s and checks both of its bytes.
   task automatic sl(input int s, input logic [2:0] y, input logic [3:0] c, input logic [7:0] v, i,
                     input logic [3:0] b, f, input logic [7:0] em, ec);
      @(posedge clk_in);
      io_slot_model_i.plug(s, y, c, v, i, b, f);
      settle();
      rd(8'(2 * s + 2), em);
      rd(8'(2 * s + 3), ec);
   endtask : sl

   task automatic t_reset;
      settle();
      rd(8'hff, 8'h01);
      rd(8'h00, 8'h20);
      rd(8'h01, 8'h88);
      for (int s = 1; s <= 8; s++) rd(8'(2 * s), 8'h21);
      rd(8'h12, 8'h00);
   endtask : t_reset

   task automatic t_global;
      @(posedge clk_in);
      com_in <= 1'b1;
      gen_in <= 1'b1;
      par_in <= 1'b1;
      stc_in <= 4'h7;
      settle();
      rd(8'h00, 8'hb7);
      rd(8'h01, 8'hc9);
   endtask : t_global

   // Error codes and their priority in slot 1.
   task automatic t_codes;
      sl(0, lay_none, 4'h0, 8'hff, 8'hff, 4'h0, 4'h0, 8'h80, 8'h00);
      sl(0, lay_none, 4'h0, 8'hff, 8'hff, 4'h3, 4'h0, 8'ha3, 8'h00);
      sl(0, lay_none, 4'h0, 8'hff, 8'hff, 4'h6, 4'ha, 8'ha6, 8'h00);
      sl(0, lay_none, 4'h0, 8'hff, 8'hff, 4'h7, 4'h0, 8'h80, 8'h00);
      sl(0, lay_none, 4'h0, 8'hff, 8'hff, 4'h0, 4'ha, 8'ha9, 8'h00);
      sl(0, lay_none, 4'h0, 8'hff, 8'hff, 4'h0, 4'h2, 8'haa, 8'h00);
      sl(0, lay_none, 4'h0, 8'hff, 8'hff, 4'h0, 4'h1, 8'hc0, 8'h00);
      wr(8'h02, 8'h55);
      rd(8'h02, 8'hc0);
      wr(8'hff, 8'h00);
      rd(8'hff, 8'h00);
      sl(0, lay_none, 4'h0, 8'hff, 8'hff, 4'h0, 4'h8, 8'h80, 8'h00);
      wr(8'hff, 8'h01);
      @(posedge clk_in);
      io_slot_model_i.pull(0);
      settle();
      rd(8'h02, 8'h21);
   endtask : t_codes

   // Channel layouts in slot 2.
   task automatic t_layouts;
      sl(1, lay_digital, 4'h4, 8'h05, 8'h03, 4'h0, 4'h0, 8'h80, 8'h1b);
      sl(1, lay_digital, 4'h2, 8'h05, 8'h03, 4'h0, 4'h0, 8'h80, 8'h0b);
      sl(1, lay_digital2, 4'h2, 8'hff, 8'hff, 4'h0, 4'h0, 8'h80, 8'h03);
      sl(1, lay_counter, 4'h1, 8'h02, 8'h01, 4'h0, 4'h0, 8'h80, 8'h0a);
      sl(1, lay_current, 4'h2, 8'h02, 8'h01, 4'h0, 4'h0, 8'h80, 8'h12);
      sl(1, 3'h5, 4'h4, 8'hff, 8'hff, 4'h0, 4'h0, 8'h80, 8'h00);
      @(posedge clk_in);
      io_slot_model_i.halt(1);
      settle();
      rd(8'h04, 8'h00);
   endtask : t_layouts

   // Dual-width module in slots 3 and 4; slot 4's own lanes are junk.
   task automatic t_dual;
      @(posedge clk_in);
      io_slot_model_i.pull(3);
      sl(2, lay_digital, 4'h8, 8'hf0, 8'h0f, 4'h0, 4'h4, 8'h80, 8'haa);
      rd(8'h08, 8'h00);
      rd(8'h09, 8'h55);
      sl(2, lay_digital, 4'h8, 8'hf0, 8'h0f, 4'h0, 4'h6, 8'haa, 8'haa);
      rd(8'h08, 8'h2a);
   endtask : t_dual

   // Reset in mid-run: control falls back to type check on, and the image follows live state again.
   task automatic t_rerun;
      wr(8'hff, 8'h00);
      @(posedge clk_in);
      rst_b_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      rst_b_in <= 1'b1;
      rd(8'hff, 8'h01);
      settle();
      rd(8'h06, 8'haa);
   endtask : t_rerun

   initial begin
      repeat (20) @(posedge clk_in);
      rst_b_in <= 1'b1;
      t_reset();
      t_global();
      t_codes();
      t_layouts();
      t_dual();
      t_rerun();
      stop_test();
   end

   // Watchdog: the run needs well under a tenth of this span.
   initial begin
      #400000;
      error_cnt++;
      stop_test();
   end
endmodule : slot_status_image_builder_bench
`default_nettype wire
